// file: rtl/rrc_pkg.sv
// What this block does
// - SDA changes only while SCL is low
// - SDA falling with SCL high starts
// - SDA rising with SCL high stops
// - Eight data bits, then acknowledge slot
// - Most significant bit goes first
// - Transmitter releases SDA during acknowledge
// - Receiver holds SDA low for acknowledge
// - Device answers address 0001000, D0 read
// - On read, device sends, master acknowledges
// - One written byte latched as control
// - Control byte bits drive enables, selects
// - Select codes map 3.3V up to 10.0V
// - Port works only while enable high
`default_nettype none
package rrc_pkg;
    localparam logic [6:0] RRC_DEV_ADDR = 7'h08;
    localparam logic [7:0] RRC_CTRL_RESET = 8'h00;
    localparam logic [3:0] RRC_BYTE_BITS = 4'h8;
    // Control byte field positions.
    localparam int RRC_LLR_EN = 7;
    localparam int RRC_LLR_SEL_LSB = 4;
    localparam int RRC_SLR_EN = 3;
    localparam int RRC_SLR_SEL = 2;
    localparam int RRC_HSB_EN = 1;
    localparam int RRC_HSA_EN = 0;
    // Controller registers on the software bus.
    localparam logic [3:0] RRC_OFF_CMD = 4'h0;
    localparam logic [3:0] RRC_OFF_STATUS = 4'h4;
    localparam int RRC_CMD_RD_BIT = 8;
    localparam int RRC_ST_BUSY = 0;
    localparam int RRC_ST_NACK = 1;
    localparam int RRC_ST_RX_LSB = 8;
    // Link clock timing.
    localparam int RRC_CLK_NS = 100;
    localparam int RRC_SCL_PERIOD_NS = 800;
    localparam int RRC_QTR_CYC = RRC_SCL_PERIOD_NS / (4 * RRC_CLK_NS);

    typedef enum logic [2:0] {
        RRC_D_IDLE = 3'b000,
        RRC_D_ADDR = 3'b001,
        RRC_D_AACK = 3'b010,
        RRC_D_WDATA = 3'b011,
        RRC_D_WACK = 3'b100,
        RRC_D_RDATA = 3'b101,
        RRC_D_RACK = 3'b110,
        RRC_D_IGNORE = 3'b111
    } rrc_dev_state_t;

    typedef enum logic [1:0] {
        RRC_H_IDLE = 2'b00,
        RRC_H_START = 2'b01,
        RRC_H_BITS = 2'b10,
        RRC_H_STOP = 2'b11
    } rrc_host_state_t;

    // Large regulator output level in tenths of a volt.
    function automatic logic [6:0] rrc_llr_decivolts(logic [2:0] code);
        logic [6:0] v;
        v = 7'h21;
        unique case (code)
            3'h0: v = 7'h21;
            3'h1: v = 7'h32;
            3'h2: v = 7'h37;
            3'h3: v = 7'h3C;
            3'h4: v = 7'h46;
            3'h5: v = 7'h4B;
            3'h6: v = 7'h50;
            3'h7: v = 7'h64;
        endcase
        return v;
    endfunction
endpackage
`default_nettype wire

// file: rtl/rrc_i2c_if.sv
`timescale 1ns/10ps
`default_nettype none
// Open-drain wires: a line is low when any enabled driver pulls it low.
interface rrc_i2c_if;
    logic scl;
    logic sda;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;

    assign scl = ~(host_scl_oe & ~host_scl_o);
    assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

    modport host (
        input scl,
        input sda,
        output host_scl_o,
        output host_scl_oe,
        output host_sda_o,
        output host_sda_oe
    );
    modport dev (
        input scl,
        input sda,
        output dev_sda_o,
        output dev_sda_oe
    );
endinterface
`default_nettype wire

// file: rtl/rrc_sync.sv
`timescale 1ns/10ps
`default_nettype none
module rrc_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Signals
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // Idle open-drain lines rest high, so both stages reset high.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= '1;
            sync_q <= '1;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule
`default_nettype wire

// file: rtl/rrc_host_end.sv
`timescale 1ns/10ps
`default_nettype none
module rrc_host_end import rrc_pkg::*; #(
    parameter int QTR_CYC = RRC_QTR_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Link
    rrc_i2c_if.host bus,
    // Software bus
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    rrc_host_state_t st_q, st_d;
    logic [1:0] ph_q, ph_d;
    logic [7:0] tmr_q, tmr_d;
    logic [3:0] bit_q, bit_d;
    logic byte_q, byte_d, rd_q, rd_d, nack_q, nack_d;
    logic [7:0] sh_q, sh_d, rx_q, rx_d, wdat_q, wdat_d;
    logic scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
    logic wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d;
    logic sda_s, busy, accept, go, tick, rx_byte;

    rrc_sync #(.WIDTH(1)) u_sync (
        .clock(clock),
        .rst_b(rst_b),
        .async_in(bus.sda),
        .sync_out(sda_s)
    );

    always_comb begin
        st_d = st_q;
        ph_d = ph_q;
        tmr_d = tmr_q;
        bit_d = bit_q;
        byte_d = byte_q;
        rd_d = rd_q;
        nack_d = nack_q;
        sh_d = sh_q;
        rx_d = rx_q;
        wdat_d = wdat_q;
        sda_oe_d = sda_oe_q;
        rdata_d = rdata_q;
        busy = (st_q != RRC_H_IDLE);
        // A new command stalls until the previous transfer is over.
        accept = !(avs_write && avs_address == RRC_OFF_CMD && busy);
        wait_d = !((avs_read || avs_write) && wait_q && accept);
        go = avs_write && !wait_q && avs_address == RRC_OFF_CMD;
        tick = (tmr_q == 8'(QTR_CYC - 1));
        rx_byte = byte_q && rd_q;
        if (!wait_d) begin
            rdata_d = 32'h0;
            if (avs_address == RRC_OFF_CMD) begin
                rdata_d[7:0] = wdat_q;
                rdata_d[RRC_CMD_RD_BIT] = rd_q;
            end else if (avs_address == RRC_OFF_STATUS) begin
                rdata_d[RRC_ST_BUSY] = busy;
                rdata_d[RRC_ST_NACK] = nack_q;
                rdata_d[RRC_ST_RX_LSB +: 8] = rx_q;
            end
        end
        if (!busy) begin
            tmr_d = 8'h00;
            ph_d = 2'h0;
            if (go) begin
                st_d = RRC_H_START;
                wdat_d = avs_writedata[7:0];
                rd_d = avs_writedata[RRC_CMD_RD_BIT];
                nack_d = 1'b0;
            end
        end else if (!tick) begin
            tmr_d = tmr_q + 8'h01;
        end else begin
            tmr_d = 8'h00;
            ph_d = ph_q + 2'h1;
            if (ph_q == 2'h3) begin
                unique case (st_q)
                    RRC_H_IDLE: ;
                    RRC_H_START: begin
                        st_d = RRC_H_BITS;
                        bit_d = 4'h0;
                        byte_d = 1'b0;
                        sh_d = {RRC_DEV_ADDR, rd_q};
                    end
                    RRC_H_BITS: begin
                        if (bit_q < RRC_BYTE_BITS) begin
                            if (rx_byte) begin
                                rx_d = {rx_q[6:0], sda_s};
                            end
                            sh_d = {sh_q[6:0], 1'b0};
                            bit_d = bit_q + 4'h1;
                        end else if (!rx_byte && sda_s) begin
                            nack_d = 1'b1;
                            st_d = RRC_H_STOP;
                        end else if (!byte_q) begin
                            byte_d = 1'b1;
                            bit_d = 4'h0;
                            sh_d = wdat_q;
                        end else begin
                            st_d = RRC_H_STOP;
                        end
                    end
                    RRC_H_STOP: st_d = RRC_H_IDLE;
                endcase
            end
        end
        // In bits and stop, quarters 0 and 1 hold SCL low; data bits move SDA only in quarter 1.
        scl_oe_d = (st_d == RRC_H_BITS || st_d == RRC_H_STOP)
            && ph_d < 2'h2;
        unique case (st_d)
            RRC_H_IDLE: sda_oe_d = 1'b0;
            RRC_H_START: sda_oe_d = (ph_d >= 2'h2);
            RRC_H_STOP: begin
                if (ph_d != 2'h0) begin
                    sda_oe_d = (ph_d != 2'h3);
                end
            end
            RRC_H_BITS: begin
                if (ph_d == 2'h1) begin
                    if (bit_d < RRC_BYTE_BITS) begin
                        sda_oe_d = !(byte_d && rd_q) && !sh_d[7];
                    end else begin
                        sda_oe_d = byte_d && rd_q;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= RRC_H_IDLE;
            ph_q <= 2'h0;
            tmr_q <= 8'h00;
            bit_q <= 4'h0;
            byte_q <= 1'b0;
            rd_q <= 1'b0;
            nack_q <= 1'b0;
            sh_q <= 8'h00;
            rx_q <= 8'h00;
            wdat_q <= 8'h00;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            wait_q <= 1'b1;
            rdata_q <= 32'h0;
        end else begin
            st_q <= st_d;
            ph_q <= ph_d;
            tmr_q <= tmr_d;
            bit_q <= bit_d;
            byte_q <= byte_d;
            rd_q <= rd_d;
            nack_q <= nack_d;
            sh_q <= sh_d;
            rx_q <= rx_d;
            wdat_q <= wdat_d;
            scl_oe_q <= scl_oe_d;
            sda_oe_q <= sda_oe_d;
            wait_q <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    assign bus.host_scl_o = 1'b0;
    assign bus.host_scl_oe = scl_oe_q;
    assign bus.host_sda_o = 1'b0;
    assign bus.host_sda_oe = sda_oe_q;
    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
endmodule
`default_nettype wire

// file: rtl/rrc_dev_end.sv
// Implementation choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module rrc_dev_end import rrc_pkg::*; (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Link
    rrc_i2c_if.dev bus,
    // Mode pin
    input wire logic enable,
    // Regulator and switch controls
    output logic large_linreg_enable,
    output logic large_linreg_select_bit2,
    output logic large_linreg_select_bit1,
    output logic large_linreg_select_bit0,
    output logic [6:0] large_linreg_level_dv,
    output logic small_linreg_enable,
    output logic small_linreg_select,
    output logic high_side_switch_b_enable,
    output logic high_side_switch_a_enable
);
    logic scl_s;
    logic sda_s;
    logic en_s;
    logic scl_p_q, scl_p_d;
    logic sda_p_q, sda_p_d;
    rrc_dev_state_t st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d;
    logic rw_q, rw_d;
    logic [7:0] output_control_byte_q, output_control_byte_d;
    logic [6:0] level_q, level_d;
    logic sda_oe_q, sda_oe_d;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    localparam logic [6:0] LEVEL_RESET =
        rrc_llr_decivolts(RRC_CTRL_RESET[RRC_LLR_SEL_LSB +: 3]);

    // SCL, SDA and the mode pin all come from outside the clock domain.
    rrc_sync #(.WIDTH(3)) u_sync (
        .clock(clock),
        .rst_b(rst_b),
        .async_in({bus.scl, bus.sda, enable}),
        .sync_out({scl_s, sda_s, en_s})
    );

    // Edge detection works on the synchronised copies only.
    assign scl_rise = scl_s && !scl_p_q;
    assign scl_fall = !scl_s && scl_p_q;
    assign start_seen = scl_s && scl_p_q && sda_p_q && !sda_s;
    assign stop_seen = scl_s && scl_p_q && !sda_p_q && sda_s;

    always_comb begin
        scl_p_d = scl_s;
        sda_p_d = sda_s;
        st_d = st_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        rw_d = rw_q;
        output_control_byte_d = output_control_byte_q;
        sda_oe_d = sda_oe_q;

        if (!en_s) begin
            // Standby: the port lets go of the bus and forgets the frame.
            st_d = RRC_D_IDLE;
            sda_oe_d = 1'b0;
        end else if (start_seen) begin
            // A repeated start aborts whatever frame was running.
            st_d = RRC_D_ADDR;
            cnt_d = 4'h0;
            sda_oe_d = 1'b0;
        end else if (stop_seen) begin
            st_d = RRC_D_IDLE;
            sda_oe_d = 1'b0;
        end else begin
            unique case (st_q)
                RRC_D_IDLE: ;
                RRC_D_IGNORE: ;
                RRC_D_ADDR, RRC_D_WDATA: begin
                    // Data is sampled on the SCL rise, MSB first.
                    if (scl_rise && cnt_q < RRC_BYTE_BITS) begin
                        sh_d = {sh_q[6:0], sda_s};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == RRC_BYTE_BITS) begin
                        cnt_d = 4'h0;
                        if (st_q == RRC_D_WDATA) begin
                            output_control_byte_d = sh_q;
                            sda_oe_d = 1'b1;
                            st_d = RRC_D_WACK;
                        end else if (sh_q[7:1] == RRC_DEV_ADDR) begin
                            rw_d = sh_q[0];
                            sda_oe_d = 1'b1;
                            st_d = RRC_D_AACK;
                        end else begin
                            st_d = RRC_D_IGNORE;
                        end
                    end
                end
                RRC_D_AACK: begin
                    // The acknowledge stays low until SCL falls again.
                    if (scl_fall) begin
                        if (rw_q) begin
                            sh_d = output_control_byte_q;
                            sda_oe_d = !output_control_byte_q[7];
                            cnt_d = 4'h1;
                            st_d = RRC_D_RDATA;
                        end else begin
                            sda_oe_d = 1'b0;
                            st_d = RRC_D_WDATA;
                        end
                    end
                end
                RRC_D_WACK: begin
                    // Further bytes in the frame overwrite the control byte.
                    if (scl_fall) begin
                        sda_oe_d = 1'b0;
                        st_d = RRC_D_WDATA;
                    end
                end
                RRC_D_RDATA: begin
                    // New bits go out only after SCL has fallen.
                    if (scl_fall) begin
                        if (cnt_q == RRC_BYTE_BITS) begin
                            sda_oe_d = 1'b0;
                            st_d = RRC_D_RACK;
                        end else begin
                            sda_oe_d = !sh_q[6];
                            sh_d = {sh_q[6:0], 1'b0};
                            cnt_d = cnt_q + 4'h1;
                        end
                    end
                end
                RRC_D_RACK: begin
                    // Only one byte is offered per read, so the master
                    // can always make its stop on a released line.
                    if (scl_fall) begin
                        st_d = RRC_D_IGNORE;
                    end
                end
            endcase
        end

        level_d = rrc_llr_decivolts(
            output_control_byte_d[RRC_LLR_SEL_LSB +: 3]);
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            st_q <= RRC_D_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            rw_q <= 1'b0;
            output_control_byte_q <= RRC_CTRL_RESET;
            level_q <= LEVEL_RESET;
            sda_oe_q <= 1'b0;
        end else begin
            scl_p_q <= scl_p_d;
            sda_p_q <= sda_p_d;
            st_q <= st_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            rw_q <= rw_d;
            output_control_byte_q <= output_control_byte_d;
            level_q <= level_d;
            sda_oe_q <= sda_oe_d;
        end
    end

    assign bus.dev_sda_o = 1'b0;
    assign bus.dev_sda_oe = sda_oe_q;

    // Decode of the latched control byte.
    assign large_linreg_enable =
        output_control_byte_q[RRC_LLR_EN];
    assign large_linreg_select_bit2 =
        output_control_byte_q[RRC_LLR_SEL_LSB + 2];
    assign large_linreg_select_bit1 =
        output_control_byte_q[RRC_LLR_SEL_LSB + 1];
    assign large_linreg_select_bit0 =
        output_control_byte_q[RRC_LLR_SEL_LSB];
    assign large_linreg_level_dv = level_q;
    assign small_linreg_enable =
        output_control_byte_q[RRC_SLR_EN];
    assign small_linreg_select =
        output_control_byte_q[RRC_SLR_SEL];
    assign high_side_switch_b_enable =
        output_control_byte_q[RRC_HSB_EN];
    assign high_side_switch_a_enable =
        output_control_byte_q[RRC_HSA_EN];
endmodule
`default_nettype wire

// file: testbench/rrc_link_properties.sv
`timescale 1ns/10ps
`default_nettype none
module rrc_link_properties import rrc_pkg::*; (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Link wires
    input wire logic scl,
    input wire logic sda,
    input wire logic host_scl_oe,
    input wire logic host_sda_oe,
    input wire logic dev_sda_oe,
    // Mode pin
    input wire logic enable
);
    logic scl_q, sda_q, rise, start_s, stop_s, framed, foreign;
    logic [3:0] bit_q, bit_d;
    logic [1:0] byte_q, byte_d;
    logic [7:0] first_q, first_d;

    assign rise = scl & ~scl_q;
    assign start_s = scl & scl_q & sda_q & ~sda;
    assign stop_s = scl & scl_q & ~sda_q & sda;
    assign framed = (bit_q == 4'h8) || (byte_q != 2'h0);
    assign foreign = first_q[7:1] != RRC_DEV_ADDR;

    // Clock pulses are counted per byte so the acknowledge slot is known.
    always_comb begin
        bit_d = bit_q;
        byte_d = byte_q;
        first_d = first_q;
        if (start_s) begin
            bit_d = 4'h0;
            byte_d = 2'h0;
        end else if (rise) begin
            if (bit_q == 4'h8) begin
                bit_d = 4'h0;
                if (byte_q != 2'h3) begin
                    byte_d = byte_q + 2'h1;
                end
            end else begin
                bit_d = bit_q + 4'h1;
            end
            if (byte_q == 2'h0 && bit_q != 4'h8) begin
                first_d = {first_q[6:0], sda};
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            bit_q <= 4'h0;
            byte_q <= 2'h0;
            first_q <= 8'h00;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            bit_q <= bit_d;
            byte_q <= byte_d;
            first_q <= first_d;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    sequence start_hold;
        scl [*2] ##[1:3] host_scl_oe;
    endsequence
    sequence ack_hold;
        dev_sda_oe [*4];
    endsequence

    dev_sda_steady_a: assert property (
        scl && $past(scl) |-> $stable(dev_sda_oe))
        else $error("device moved SDA while SCL high");
    start_shape_a: assert property (
        $rose(host_sda_oe) && scl |-> start_hold)
        else $error("start condition badly formed");
    stop_idle_a: assert property (
        $fell(host_sda_oe) && scl |-> !host_scl_oe [*4])
        else $error("bus not idle after stop");
    // The stop's own clock pulse counts as the first bit of a next byte.
    stop_whole_a: assert property (
        stop_s |-> bit_q == 4'h1 && byte_q != 2'h0)
        else $error("stop inside a byte");
    host_release_a: assert property (
        rise && bit_q == 4'h8 && (byte_q == 2'h0 || !first_q[0])
        |-> !host_sda_oe)
        else $error("host drove SDA in acknowledge slot");
    addr_ack_a: assert property (
        rise && bit_q == 4'h8 && byte_q == 2'h0 && !foreign && enable
        |-> ack_hold)
        else $error("own address not acknowledged");
    foreign_quiet_a: assert property (
        scl && scl_q && framed && foreign |-> !dev_sda_oe)
        else $error("device drove SDA for foreign address");
    read_ack_a: assert property (
        rise && bit_q == 4'h8 && byte_q == 2'h1 && first_q == 8'h11
        |-> host_sda_oe && !dev_sda_oe)
        else $error("read byte acknowledge wrong");
    standby_quiet_a: assert property (
        !enable [*5] |-> !dev_sda_oe)
        else $error("device active in standby");
endmodule
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench import rrc_pkg::*;;
    localparam logic [6:0] LEVEL_TBL [8] = '{7'h21, 7'h32, 7'h37, 7'h3C,
        7'h46, 7'h4B, 7'h50, 7'h64};
    logic clock, rst_b, en, av_rd, av_wr, av_wait, bb_d, mon_b;
    logic [3:0] av_addr;
    logic [31:0] av_wdata, av_rdata, rd;
    logic [7:0] last;
    logic [6:0] lvl;
    wire [7:0] o1;
    wire [7:0] o2;
    int failures, compares;

    rrc_i2c_if u_rrc_i2c_if();
    rrc_i2c_if u_rrc_i2c_if_b();
    rrc_host_end u_rrc_host_end (.clock(clock), .rst_b(rst_b),
        .bus(u_rrc_i2c_if.host), .avs_address(av_addr),
        .avs_read(av_rd), .avs_write(av_wr), .avs_writedata(av_wdata),
        .avs_readdata(av_rdata), .avs_waitrequest(av_wait));
    rrc_dev_end u_rrc_dev_end (.clock(clock), .rst_b(rst_b),
        .bus(u_rrc_i2c_if.dev), .enable(en), .large_linreg_enable(o1[7]),
        .large_linreg_select_bit2(o1[6]), .large_linreg_select_bit1(o1[5]),
        .large_linreg_select_bit0(o1[4]), .large_linreg_level_dv(lvl),
        .small_linreg_enable(o1[3]), .small_linreg_select(o1[2]),
        .high_side_switch_b_enable(o1[1]),
        .high_side_switch_a_enable(o1[0]));
    // Second device is driven by hand to break the address rule.
    rrc_dev_end u_rrc_dev_end_b (.clock(clock), .rst_b(rst_b),
        .bus(u_rrc_i2c_if_b.dev), .enable(1'b1),
        .large_linreg_enable(o2[7]), .large_linreg_select_bit2(o2[6]),
        .large_linreg_select_bit1(o2[5]), .large_linreg_select_bit0(o2[4]),
        .large_linreg_level_dv(), .small_linreg_enable(o2[3]),
        .small_linreg_select(o2[2]), .high_side_switch_b_enable(o2[1]),
        .high_side_switch_a_enable(o2[0]));
    // During the address test the checker follows the hand-driven link;
    // the host end is idle then, so its drive signals stay on the main link.
    rrc_link_properties u_rrc_link_properties (.clock(clock),
        .rst_b(rst_b),
        .scl(mon_b ? u_rrc_i2c_if_b.scl : u_rrc_i2c_if.scl),
        .sda(mon_b ? u_rrc_i2c_if_b.sda : u_rrc_i2c_if.sda),
        .host_scl_oe(u_rrc_i2c_if.host_scl_oe),
        .host_sda_oe(u_rrc_i2c_if.host_sda_oe),
        .dev_sda_oe(mon_b ? u_rrc_i2c_if_b.dev_sda_oe
            : u_rrc_i2c_if.dev_sda_oe),
        .enable(en));

    task results;
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: %s", $time, m);
        end
    endtask

    // Waits end only when the answer comes or the watchdog runs out.
    task av(input logic wr, input logic [3:0] a, input logic [31:0] d);
        av_addr <= a;
        av_wdata <= d;
        av_wr <= wr;
        av_rd <= !wr;
        @(posedge clock);
        while (av_wait !== 1'b0) begin
            @(posedge clock);
        end
        rd = av_rdata;
        av_wr <= 1'b0;
        av_rd <= 1'b0;
        @(posedge clock);
    endtask

    task idle;
        av(1'b0, RRC_OFF_STATUS, 32'h0);
        while (rd[RRC_ST_BUSY] !== 1'b0) begin
            av(1'b0, RRC_OFF_STATUS, 32'h0);
        end
    endtask

    // One quarter of a hand-made SCL period; arguments are line levels.
    task bb_q(input logic c, input logic d);
        u_rrc_i2c_if_b.host_scl_oe <= ~c;
        u_rrc_i2c_if_b.host_sda_oe <= ~d;
        repeat (2) @(posedge clock);
    endtask

    task bb_byte(input logic [7:0] b, output logic ack);
        logic d;
        for (int k = 0; k < 9; k++) begin
            d = (k < 8) ? b[7 - k] : 1'b1;
            bb_q(1'b0, bb_d);
            bb_q(1'b0, d);
            bb_d = d;
            bb_q(1'b1, d);
            ack = !u_rrc_i2c_if_b.sda;
            bb_q(1'b1, d);
        end
    endtask

    task bb_frame(input logic [7:0] a, input logic [7:0] b,
                  output logic a1, output logic a2);
        bb_q(1'b1, 1'b1);
        bb_q(1'b1, 1'b0);
        bb_d = 1'b0;
        bb_byte(a, a1);
        bb_byte(b, a2);
        bb_q(1'b0, bb_d);
        bb_q(1'b0, 1'b0);
        bb_q(1'b1, 1'b0);
        bb_q(1'b1, 1'b1);
        bb_d = 1'b1;
    endtask

    task t_reset;
        chk(o1, 8'h00, "control outputs after reset");
        chk(lvl, 7'h21, "level after reset");
        av(1'b0, RRC_OFF_STATUS, 32'h0);
        chk(rd, 32'h0, "status after reset");
        av(1'b0, 4'hC, 32'h0);
        chk(rd, 32'h0, "unmapped read");
    endtask

    // Writes go back to back, so each one stalls until the last is done.
    task t_codes;
        logic [7:0] b;
        for (int i = 0; i < 9; i++) begin
            b = {i[0], i[2:0], ~i[0], i[1], i[2], i[0]};
            if (i < 8) begin
                av(1'b1, RRC_OFF_CMD, {24'h0, b});
            end else begin
                idle();
            end
            if (i > 0) begin
                chk(o1, last, "control outputs");
                chk(lvl, LEVEL_TBL[last[6:4]], "level");
            end
            if (i < 8) begin
                last = b;
            end
        end
        chk(rd[RRC_ST_NACK], 1'b0, "write acknowledged");
    endtask

    task t_read;
        av(1'b1, RRC_OFF_CMD, 32'h100);
        idle();
        chk(rd[15:8], last, "byte read back");
        chk(rd[RRC_ST_NACK], 1'b0, "read acknowledged");
        chk(o1, last, "read keeps control");
    endtask

    task t_standby;
        en <= 1'b0;
        repeat (5) @(posedge clock);
        av(1'b1, RRC_OFF_CMD, 32'h5A);
        idle();
        chk(rd[RRC_ST_NACK], 1'b1, "standby nack");
        chk(o1, last, "standby keeps control");
        en <= 1'b1;
        repeat (5) @(posedge clock);
        av(1'b1, RRC_OFF_CMD, 32'hC3);
        idle();
        chk(rd[RRC_ST_NACK], 1'b0, "active again");
        chk(o1, 8'hC3, "control after standby");
    endtask

    task t_foreign;
        logic a1, a2;
        mon_b <= 1'b1;
        bb_frame(8'h20, 8'hFF, a1, a2);
        chk({a1, a2}, 2'b00, "foreign frame acknowledged");
        chk(o2, 8'h00, "foreign frame changed control");
        bb_frame(8'h10, 8'h96, a1, a2);
        chk({a1, a2}, 2'b11, "own frame acknowledge");
        chk(o2, 8'h96, "own frame control");
    endtask

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    initial begin
        repeat (30000) @(posedge clock);
        $display("ERROR %0t: watchdog ran out", $time);
        failures++;
        results();
    end

    initial begin
        rst_b = 1'b0;
        en = 1'b1;
        bb_d = 1'b1;
        mon_b = 1'b0;
        av_rd = 1'b0;
        av_wr = 1'b0;
        av_addr = 4'h0;
        av_wdata = 32'h0;
        u_rrc_i2c_if_b.host_scl_o = 1'b0;
        u_rrc_i2c_if_b.host_sda_o = 1'b0;
        u_rrc_i2c_if_b.host_scl_oe = 1'b0;
        u_rrc_i2c_if_b.host_sda_oe = 1'b0;
        failures = 0;
        compares = 0;
        repeat (20) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        t_reset();
        t_codes();
        t_read();
        t_standby();
        t_foreign();
        results();
    end
endmodule
`default_nettype wire
